// >>> hw/blink_timer.sv
`timescale 1ns/1ps
module blink_timer
    import status_pkg::*;
(
    input  wire logic   clk,
    input  wire logic   rst,
    input  wire logic   ce,
    input  wire net_state_t req_state,
    output logic        lamp_on,
    output net_state_t  cur_state
);
    logic [CNT_W-1:0] cnt_r;
    logic [CNT_W-1:0] cnt_nxt;
    net_state_t       st_r;
    net_state_t       st_nxt;
    logic [CNT_W-1:0] period;
    logic [CNT_W-1:0] on_time;

    always_comb begin
        period  = CNT_W'(FAST_PERIOD_CYC);
        on_time = CNT_W'(FAST_ON_CYC);
        case (st_r)
            NET_REG: begin
                period  = CNT_W'(SLOW_PERIOD_CYC);
                on_time = CNT_W'(SLOW_ON_CYC);
            end
            default: begin
                period  = CNT_W'(FAST_PERIOD_CYC);
                on_time = CNT_W'(FAST_ON_CYC);
            end
        endcase
    end

    // steady states switch at once; blink patterns wait for the period end
    always_comb begin
        cnt_nxt = cnt_r + CNT_W'(1);
        st_nxt  = st_r;
        if (cnt_r == period - CNT_W'(1)) begin
            cnt_nxt = '0;
            st_nxt  = req_state;
        end
        if (req_state == NET_OFF || req_state == NET_CALL || st_r == NET_OFF || st_r == NET_CALL) begin
            if (req_state != st_r) begin
                cnt_nxt = '0;
                st_nxt  = req_state;
            end
        end
    end

    always_ff @(posedge clk) begin
        if (rst) begin
            cnt_r <= '0;
            st_r  <= NET_OFF;
        end else if (ce) begin
            cnt_r <= cnt_nxt;
            st_r  <= st_nxt;
        end
    end

    always_comb begin
        case (st_r)
            NET_OFF:  lamp_on = 1'b0;
            NET_CALL: lamp_on = 1'b1;
            default:  lamp_on = (cnt_r < on_time);
        endcase
    end
    assign cur_state = st_r;

    a_fast_on_edge: assert property (@(posedge clk) disable iff (rst)
        (ce && st_r == NET_SEARCH && cnt_r == CNT_W'(FAST_ON_CYC - 1) && st_nxt == NET_SEARCH)
        |=> !lamp_on)
        else $error("fast blink on-time wrong");
    a_slow_on_edge: assert property (@(posedge clk) disable iff (rst)
        (ce && st_r == NET_REG && cnt_r == CNT_W'(SLOW_ON_CYC - 1) && st_nxt == NET_REG)
        |=> !lamp_on)
        else $error("slow blink on-time wrong");
    a_period_wrap: assert property (@(posedge clk) disable iff (rst)
        (ce && st_r == NET_REG && cnt_r == CNT_W'(SLOW_PERIOD_CYC - 1) && req_state == NET_REG)
        |=> cnt_r == '0 && lamp_on)
        else $error("slow period does not wrap");
    a_no_midswitch: assert property (@(posedge clk) disable iff (rst)
        (ce && st_r == NET_SEARCH && req_state == NET_REG && cnt_r != period - CNT_W'(1))
        |=> st_r == NET_SEARCH)
        else $error("pattern switched mid period");
    c_fast: cover property (@(posedge clk) st_r == NET_SEARCH && cnt_r == CNT_W'(FAST_ON_CYC));
    c_slow: cover property (@(posedge clk) st_r == NET_REG && cnt_r == '0);
    c_call: cover property (@(posedge clk) st_r == NET_CALL);
endmodule : blink_timer

// >>> hw/module_status_indicators.sv
`timescale 1ns/1ps
// Overview of operation
// - searching or unregistered: 1 s, half on
// - registered: 3 s period, 0.3 s on
// - off dark, call steady lit
// - lamp on gpio 1 after reset
// - ready low while booting
// - ready high once commands accepted
// - ready on gpio 8 after reset
// - thermal watch drives chosen pin high while temp_now >= temp_max, low otherwise
module module_status_indicators
    import status_pkg::*;
(
    input  wire logic         clk,
    input  wire logic         rst,
    input  wire logic         ce,
    input  wire net_state_t   net_state,
    input  wire logic         boot_done,
    input  wire gpio_cfg_t    gpio_cfg,
    input  wire logic         cfg_load,
    input  wire thermal_cfg_t thermal,
    output logic [GPIO_N-1:0] gpio_o,
    output logic [GPIO_N-1:0] gpio_oe_n,
    output logic              network_status_lamp,
    output logic              software_ready_flag,
    output logic              thermal_alarm
);
    logic [GPIO_N-1:0] alt_r;
    logic [GPIO_N-1:0] alt_nxt;
    logic [GPIO_N-1:0] out_r;
    logic [GPIO_N-1:0] out_nxt;
    logic [GPIO_N-1:0] dir_r;
    logic [GPIO_N-1:0] dir_nxt;
    logic [GPIO_N-1:0] pin_r;
    logic [GPIO_N-1:0] pin_nxt;
    logic [GPIO_N-1:0] oen_r;
    logic [GPIO_N-1:0] oen_nxt;
    logic              lamp_r;
    logic              lamp_nxt;
    logic              ready_r;
    logic              ready_nxt;
    logic              hot_r;
    logic              hot_nxt;
    logic              lamp_raw;
    logic [3:0]        hot_pin;
    net_state_t        cur_state;

    blink_timer blink_timer_i (
        .clk       (clk),
        .rst       (rst),
        .ce        (ce),
        .req_state (net_state),
        .lamp_on   (lamp_raw),
        .cur_state (cur_state)
    );

    // ready only rises; a new boot needs a reset
    always_comb begin
        ready_nxt = ready_r | boot_done;
    end

    always_ff @(posedge clk) begin
        if (rst) begin
            ready_r <= 1'b0;
        end else if (ce) begin
            ready_r <= ready_nxt;
        end
    end

    // compared afresh each cycle, so the alarm drops as soon as the reading falls back
    always_comb begin
        hot_nxt = thermal.watch_en && (thermal.temp_now >= thermal.temp_max);
        hot_pin = (thermal.pin_sel < 4'(GPIO_N)) ? thermal.pin_sel : 4'h0;
    end

    always_ff @(posedge clk) begin
        if (rst) begin
            hot_r <= 1'b0;
        end else if (ce) begin
            hot_r <= hot_nxt;
        end
    end

    // pad setup changes only on an explicit load strobe
    always_comb begin
        alt_nxt = alt_r;
        out_nxt = out_r;
        dir_nxt = dir_r;
        if (cfg_load) begin
            alt_nxt = gpio_cfg.alt_en;
            out_nxt = gpio_cfg.gpio_out;
            dir_nxt = gpio_cfg.gpio_dir;
        end
    end

    always_ff @(posedge clk) begin
        if (rst) begin
            alt_r <= ALT_RESET;
            out_r <= '0;
            dir_r <= '0;
        end else if (ce) begin
            alt_r <= alt_nxt;
            out_r <= out_nxt;
            dir_r <= dir_nxt;
        end
    end

    // one flop here keeps the lamp output in step with its copy on the pad
    always_comb begin
        lamp_nxt = lamp_raw;
    end

    always_ff @(posedge clk) begin
        if (rst) begin
            lamp_r <= 1'b0;
        end else if (ce) begin
            lamp_r <= lamp_nxt;
        end
    end

    // pin mux: alternate function, thermal override, else plain gpio
    generate
        for (genvar i = 0; i < GPIO_N; i++) begin : g_pin
            always_comb begin
                pin_nxt[i] = out_r[i];
                oen_nxt[i] = ~dir_r[i];
                if (alt_r[i] && i == LAMP_GPIO_IDX) begin
                    pin_nxt[i] = lamp_raw;
                    oen_nxt[i] = 1'b0;
                end else if (alt_r[i] && i == READY_GPIO_IDX) begin
                    pin_nxt[i] = ready_r;
                    oen_nxt[i] = 1'b0;
                end
                if (thermal.watch_en && hot_pin == 4'(i)) begin
                    pin_nxt[i] = hot_r;
                    oen_nxt[i] = 1'b0;
                end
            end

            a_plain_pad: assert property (@(posedge clk) disable iff (rst)
                ce && !(alt_r[i] && (i == LAMP_GPIO_IDX || i == READY_GPIO_IDX))
                && !(thermal.watch_en && hot_pin == 4'(i))
                |=> gpio_o[i] == $past(out_r[i]) && gpio_oe_n[i] == !$past(dir_r[i]))
                else $error("plain pad not following its setup");
        end
    endgenerate

    always_ff @(posedge clk) begin
        if (rst) begin
            pin_r <= '0;
            oen_r <= ~ALT_RESET;
        end else if (ce) begin
            pin_r <= pin_nxt;
            oen_r <= oen_nxt;
        end
    end

    assign gpio_o              = pin_r;
    assign gpio_oe_n           = oen_r;
    assign network_status_lamp = lamp_r;
    assign software_ready_flag = ready_r;
    assign thermal_alarm       = hot_r;

    a_ready_boot: assert property (@(posedge clk) disable iff (rst)
        !ready_r && !boot_done |=> !software_ready_flag)
        else $error("ready rose during boot");

    a_ready_rise: assert property (@(posedge clk) disable iff (rst)
        ce && boot_done |=> software_ready_flag ##1 (!ce || software_ready_flag))
        else $error("ready not raised");

    a_ready_sticky: assert property (@(posedge clk) disable iff (rst)
        software_ready_flag |=> software_ready_flag)
        else $error("ready fell without reset");

    a_ready_pin: assert property (@(posedge clk) disable iff (rst)
        ce && alt_r[READY_GPIO_IDX] && !(thermal.watch_en && hot_pin == 4'(READY_GPIO_IDX))
        |=> gpio_o[READY_GPIO_IDX] == $past(ready_r) && !gpio_oe_n[READY_GPIO_IDX])
        else $error("ready not on its pin");

    a_lamp_pin: assert property (@(posedge clk) disable iff (rst)
        ce && alt_r[LAMP_GPIO_IDX] && !(thermal.watch_en && hot_pin == 4'(LAMP_GPIO_IDX))
        |=> gpio_o[LAMP_GPIO_IDX] == network_status_lamp && !gpio_oe_n[LAMP_GPIO_IDX])
        else $error("lamp not on its pin");

    a_cfg_load: assert property (@(posedge clk) disable iff (rst)
        ce && cfg_load |=> alt_r == $past(gpio_cfg.alt_en))
        else $error("pad setup not loaded");

    a_hot_high: assert property (@(posedge clk) disable iff (rst)
        ce && thermal.watch_en && thermal.temp_now >= thermal.temp_max |=> thermal_alarm)
        else $error("thermal alarm not raised");

    // the pad lags the alarm by one flop, so only a setup held for two edges is judged
    a_hot_pin: assert property (@(posedge clk) disable iff (rst)
        (ce && thermal.watch_en && thermal.temp_now >= thermal.temp_max) ##1 (ce && $stable(thermal))
        |=> thermal_alarm && gpio_o[$past(hot_pin)] && !gpio_oe_n[$past(hot_pin)])
        else $error("thermal pin not high");

    a_hot_low: assert property (@(posedge clk) disable iff (rst)
        ce && !(thermal.watch_en && thermal.temp_now >= thermal.temp_max) |=> !thermal_alarm)
        else $error("thermal alarm without cause");

    a_hot_drive: assert property (@(posedge clk) disable iff (rst)
        ce && thermal.watch_en |=> !gpio_oe_n[$past(hot_pin)])
        else $error("thermal pin not driven");

    a_pin_clip: assert property (@(posedge clk) disable iff (rst)
        ce && thermal.watch_en && thermal.pin_sel >= 4'(GPIO_N)
        |=> !gpio_oe_n[0] && gpio_o[0] == $past(hot_r))
        else $error("out of range thermal pin not folded");

    a_call_lit: assert property (@(posedge clk) disable iff (rst)
        ce && cur_state == NET_CALL |=> network_status_lamp)
        else $error("lamp dark during call");

    a_off_dark: assert property (@(posedge clk) disable iff (rst)
        ce && cur_state == NET_OFF |=> !network_status_lamp)
        else $error("lamp lit while off");

    a_freeze_all: assert property (@(posedge clk) disable iff (rst)
        !ce |=> $stable(gpio_o) && $stable(gpio_oe_n) && $stable(network_status_lamp)
        && $stable(software_ready_flag) && $stable(thermal_alarm))
        else $error("outputs moved while frozen");

    a_reset_vals: assert property (@(posedge clk)
        rst |=> gpio_oe_n == ~ALT_RESET && gpio_o == '0 && !software_ready_flag
        && !thermal_alarm && !network_status_lamp)
        else $error("outputs wrong after reset");

    c_ready: cover property (@(posedge clk) $rose(software_ready_flag));
    c_hot: cover property (@(posedge clk) $rose(thermal_alarm));
endmodule : module_status_indicators

// >>> hw/status_pkg.sv
package status_pkg;

    localparam int unsigned CLK_HZ          = 250_000_000;
    localparam int unsigned FAST_PERIOD_MS  = 1000;
    localparam int unsigned FAST_ON_MS      = 500;
    localparam int unsigned SLOW_PERIOD_MS  = 3000;
    localparam int unsigned SLOW_ON_MS      = 300;
    localparam int unsigned MS_CYC          = CLK_HZ / 1000;
    localparam int unsigned FAST_PERIOD_CYC = FAST_PERIOD_MS * MS_CYC;
    localparam int unsigned FAST_ON_CYC     = FAST_ON_MS * MS_CYC;
    localparam int unsigned SLOW_PERIOD_CYC = SLOW_PERIOD_MS * MS_CYC;
    localparam int unsigned SLOW_ON_CYC     = SLOW_ON_MS * MS_CYC;
    localparam int unsigned CNT_W           = 30;
    localparam int unsigned GPIO_N          = 10;
    localparam int unsigned LAMP_GPIO_IDX   = 0;
    localparam int unsigned READY_GPIO_IDX  = 7;
    localparam int unsigned TEMP_W          = 12;
    localparam logic [GPIO_N-1:0] ALT_RESET = 10'h081;

    typedef enum logic [3:0] {
        NET_OFF    = 4'h1,
        NET_SEARCH = 4'h2,
        NET_REG    = 4'h4,
        NET_CALL   = 4'h8
    } net_state_t;

    typedef struct packed {
        logic [GPIO_N-1:0] alt_en;
        logic [GPIO_N-1:0] gpio_out;
        logic [GPIO_N-1:0] gpio_dir;
    } gpio_cfg_t;

    typedef struct packed {
        logic              watch_en;
        logic [TEMP_W-1:0] temp_max;
        logic [TEMP_W-1:0] temp_now;
        logic [3:0]        pin_sel;
    } thermal_cfg_t;

endpackage : status_pkg

// >>> test/status_far_side.sv
`timescale 1ns/1ps
module status_far_side (
    input  wire logic clk,
    input  wire logic lamp_pin,
    input  wire logic lamp_oe_n,
    input  wire logic ready_pin,
    input  wire logic ready_oe_n,
    output logic      led_lit,
    output logic      host_may_send
);
    // transistor base sees a pull-down when the pad is released, so an undriven pad is dark
    assign led_lit = lamp_pin & ~lamp_oe_n;
    initial host_may_send = 1'b0;
    // host holds every command back until it has seen ready high on the pin
    always @(posedge clk) begin
        // a released ready pad reads low at the host through its pull-down
        host_may_send <= ready_pin & ~ready_oe_n;
    end
endmodule : status_far_side

// >>> test/test_module_status_indicators.sv
`timescale 1ns/1ps
module test_module_status_indicators
    import status_pkg::*;
;
    logic              clk, rst, ce, boot_done, cfg_load;
    net_state_t        net_state;
    gpio_cfg_t         gpio_cfg;
    thermal_cfg_t      thermal;
    logic [GPIO_N-1:0] gpio_o, gpio_oe_n;
    logic              lamp, ready, alarm, led_lit, host_may_send;
    int                num_errors, checked;

    module_status_indicators module_status_indicators_i (
        .clk(clk), .rst(rst), .ce(ce), .net_state(net_state), .boot_done(boot_done),
        .gpio_cfg(gpio_cfg), .cfg_load(cfg_load), .thermal(thermal), .gpio_o(gpio_o),
        .gpio_oe_n(gpio_oe_n), .network_status_lamp(lamp), .software_ready_flag(ready),
        .thermal_alarm(alarm));

    status_far_side status_far_side_i (
        .clk(clk), .lamp_pin(gpio_o[0]), .lamp_oe_n(gpio_oe_n[0]), .ready_pin(gpio_o[7]),
        .ready_oe_n(gpio_oe_n[7]), .led_lit(led_lit), .host_may_send(host_may_send));

    initial begin
        clk = 1'b0;
        forever #2 clk = ~clk;
    end

    task automatic step(input int n);
        repeat (n) @(posedge clk);
        #1;
    endtask : step

    task automatic chk_bit(input logic got, input logic exp);
        checked++;
        if (got !== exp) begin
            num_errors++;
            $display("Error %0t: bit got %b exp %b", $time, got, exp);
        end
    endtask : chk_bit

    task automatic chk_vec(input logic [GPIO_N-1:0] got, input logic [GPIO_N-1:0] exp);
        checked++;
        if (got !== exp) begin
            num_errors++;
            $display("Error %0t: pins got %h exp %h", $time, got, exp);
        end
    endtask : chk_vec

    task automatic end_sim();
        if (num_errors == 0 && checked > 0) begin
            $display("TB: PASS");
        end else begin
            $display("TB: FAIL");
        end
        $finish;
    endtask : end_sim

    task automatic t_reset();
        chk_vec(gpio_oe_n, 10'h37E);
        chk_vec(gpio_o, 10'h000);
        chk_bit(lamp, 1'b0);
    endtask : t_reset

    // a boot pulse while frozen must be ignored; a live one sets ready after exactly one edge
    task automatic t_ready();
        int i;
        @(posedge clk);
        ce        <= 1'b0;
        boot_done <= 1'b1;
        @(posedge clk);
        ce        <= 1'b1;
        boot_done <= 1'b0;
        step(3);
        chk_bit(ready, 1'b0);
        chk_bit(gpio_o[7], 1'b0);
        chk_bit(gpio_oe_n[7], 1'b0);
        chk_bit(host_may_send, 1'b0);
        @(posedge clk);
        boot_done <= 1'b1;
        @(posedge clk);
        boot_done <= 1'b0;
        #1;
        chk_bit(ready, 1'b1);
        for (i = 0; i < 10 && host_may_send !== 1'b1; i++) begin
            step(1);
        end
        if (i == 10) begin
            num_errors++;
            end_sim();
        end
        chk_bit(gpio_o[7], 1'b1);
        chk_bit(gpio_oe_n[7], 1'b0);
    endtask : t_ready

    // a steady sample every 500 cycles; periods are too long to watch a whole blink
    task automatic t_lamp(input net_state_t st, input logic exp);
        @(posedge clk);
        net_state <= st;
        step(3);
        repeat (8) begin
            chk_bit(lamp, exp);
            chk_bit(led_lit, exp);
            step(500);
        end
    endtask : t_lamp

    task automatic t_thermal();
        @(posedge clk);
        gpio_cfg <= '{alt_en: 10'h081, gpio_out: 10'h004, gpio_dir: 10'h004};
        cfg_load <= 1'b1;
        thermal  <= '{watch_en: 1'b1, temp_max: 12'h800, temp_now: 12'h7FF, pin_sel: 4'h5};
        @(posedge clk);
        cfg_load <= 1'b0;
        step(3);
        chk_bit(alarm, 1'b0);
        chk_vec(gpio_o, 10'h085);
        chk_vec(gpio_oe_n, 10'h35A);
        @(posedge clk);
        thermal.temp_now <= 12'h800;
        step(3);
        chk_bit(alarm, 1'b1);
        chk_vec(gpio_o, 10'h0A5);
        chk_vec(gpio_oe_n, 10'h35A);
        @(posedge clk);
        thermal.watch_en <= 1'b0;
        step(3);
        chk_bit(alarm, 1'b0);
        chk_vec(gpio_o, 10'h085);
        chk_vec(gpio_oe_n, 10'h37A);
    endtask : t_thermal

    // a mid-run reset drops ready and hands gpio 1 and 8 back to lamp and ready
    task automatic t_rereset();
        @(posedge clk);
        rst <= 1'b1;
        repeat (5) @(posedge clk);
        rst <= 1'b0;
        step(1);
        chk_bit(ready, 1'b0);
        chk_bit(host_may_send, 1'b0);
        chk_vec(gpio_oe_n, 10'h37E);
        chk_vec(gpio_o, 10'h000);
        chk_bit(lamp, 1'b0);
        step(3);
        chk_bit(lamp, 1'b1);
        chk_bit(led_lit, 1'b1);
        chk_bit(ready, 1'b0);
    endtask : t_rereset

    initial begin
        rst        = 1'b1;
        ce         = 1'b1;
        net_state  = NET_OFF;
        boot_done  = 1'b0;
        cfg_load   = 1'b0;
        gpio_cfg   = '0;
        thermal    = '0;
        num_errors = 0;
        checked    = 0;
        repeat (5) @(posedge clk);
        rst <= 1'b0;
        step(1);
        t_reset();
        t_ready();
        t_lamp(NET_OFF, 1'b0);
        t_lamp(NET_SEARCH, 1'b1);
        t_lamp(NET_CALL, 1'b1);
        t_lamp(NET_OFF, 1'b0);
        t_lamp(NET_REG, 1'b1);
        t_thermal();
        t_rereset();
        end_sim();
    end
endmodule : test_module_status_indicators
